/* File: rtl/igw_ctrl.sv */
// What this block does
// - Option bit 5 picks source-two edge polarity
// - Bit 4 enables interrupts; NMI never masked
// - NMI served with enable low, no wake
// - Option register clears to zero on reset
// - Masked timer and converter events drive vector four
// - Auto-reload overflow, compare, edge drive vector three
// - Ports A,B to vector one; C to two
// - Wait halts core, clock and peripherals run
// - Wait exit by interrupt has no delay
// - Reset during sleep runs the plain reset
// - Stop halts oscillator until interrupt or reset
// - Stop exit by interrupt waits for oscillator
// - Active watchdog turns stop into wait
// - From main routine, service wake interrupt first
// - From NMI routine, resume, stay, no service
// - From interrupt routine, maskable wake just resumes
// - From interrupt routine, NMI wake served first
// - Enable low means only reset wakes
// - Sleep skipped when enabled request pending
// - Wake leaves oscillator selection unchanged
// - Source two edge only, rising or falling
// - Pin feeds interrupts only as pull-up input
//
// Purpose: Interrupt enables, vector routing and wait/stop sequencing of the core
// Assumes: All inputs synchronous to clk_i; core pulses sleep and ack strobes
// Notes: Priority and vector fetch stay in the core; this block only requests
`timescale 1ns/1ns
module igw_ctrl (
	input wire logic clk_i, // Core clock, 10 MHz
	input wire logic rst_i, // Synchronous reset, pin or watchdog
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic nmi_i, // Non-maskable request line, rising edge
	input wire logic timer_zero_flag_i, // Timer overflow flag
	input wire logic adc_eoc_flag_i, // Converter end of conversion
	input wire logic ar_overflow_flag_i, // Auto-reload overflow flag
	input wire logic ar_compare_flag_i, // Auto-reload compare flag
	input wire logic ar_edge_flag_i, // Auto-reload input edge flag
	input wire logic [7:0] port_a_i, // Port A pin levels
	input wire logic [7:0] port_b_i, // Port B pin levels
	input wire logic [7:0] port_c_i, // Port C pin levels
	input wire logic [4:0] irq_ack_i, // Core entered routine of vector n
	input wire logic [1:0] core_mode_i, // Current core execution mode
	input wire logic sleep_wait_i, // Core executes a wait instruction
	input wire logic sleep_stop_i, // Core executes a stop instruction
	input wire logic watchdog_active_i, // Watchdog running, hardware or software
	output logic [4:0] irq_req_o, // Requests per vector to the core
	output logic halt_o, // Core must not fetch instructions
	output logic osc_run_o, // Oscillator enable
	output logic [1:0] osc_select_o, // Oscillator source selection
	output logic resume_o, // One-cycle pulse: core leaves sleep
	output logic resume_service_o, // With resume: take interrupt before next instr
	output logic skip_o // One-cycle pulse: sleep instruction skipped
);
	// Register state
	logic [7:0] interrupt_option_reg; // Edge polarity and global enable
	logic [7:0] src_ctrl; // Peripheral masks and clock select
	logic [23:0] port_a_pin_irq_config; // Port A direction, option, data
	logic [23:0] port_b_pin_irq_config; // Port B direction, option, data
	logic [23:0] port_c_pin_irq_config; // Port C direction, option, data
	logic [7:0] next_interrupt_option_reg;
	logic [7:0] next_src_ctrl;
	logic [23:0] next_port_a, next_port_b, next_port_c;
	logic [31:0] next_dat;
	logic next_ack;
	// Latches and sequencer state
	logic nmi_prev, c_prev, nmi_latch, c_latch;
	logic next_nmi_latch, next_c_latch;
	igw_pkg::igw_state_type state, next_state;
	logic [10:0] stab_cnt, next_stab_cnt;
	logic [1:0] mode_at_sleep, next_mode_at_sleep;
	logic next_resume, next_resume_service, next_skip;
	// Decoded requests
	logic global_irq_enable, edge_polarity_select;
	logic [7:0] pin_en_a, pin_en_b, pin_en_c;
	logic c_active, any_pending, wake;
	logic bus_req, sleep_req;

	// Pin enabled for interrupts: input, option set, data clear
	function automatic logic [7:0] pin_irq_en(input logic [23:0] cfg);
		pin_irq_en = ~cfg[7:0] & cfg[igw_pkg::PCFG_OPT_LSB +: 8] &
			~cfg[igw_pkg::PCFG_DATA_LSB +: 8];
	endfunction

	// Byte-lane merge for a register write
	function automatic logic [23:0] lane_merge(input logic [23:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		lane_merge = old;
		for (int i = 0; i < 3; i++)
		begin
			if (sel[i])
			begin
				lane_merge[8*i +: 8] = d[8*i +: 8];
			end
		end
	endfunction

	// Field decode
	assign global_irq_enable = interrupt_option_reg[igw_pkg::IOR_GEN_BIT];
	assign edge_polarity_select = interrupt_option_reg[igw_pkg::IOR_EDGE_POL_BIT];
	assign pin_en_a = pin_irq_en(port_a_pin_irq_config);
	assign pin_en_b = pin_irq_en(port_b_pin_irq_config);
	assign pin_en_c = pin_irq_en(port_c_pin_irq_config);
	// Polarity-adjusted port C level; latch catches its rising edge
	assign c_active = |(pin_en_c & (port_c_i ^ {8{~edge_polarity_select}}));

	// Vector requests, maskable ones gated by the global enable
	always_comb
	begin
		irq_req_o = 5'h00;
		irq_req_o[igw_pkg::VEC_NMI] = nmi_latch;
		// Ports A/B request on a low level of any enabled pin
		irq_req_o[igw_pkg::VEC_PORT_AB] = global_irq_enable &
			|((pin_en_a & ~port_a_i) | (pin_en_b & ~port_b_i));
		irq_req_o[igw_pkg::VEC_PORT_C] = global_irq_enable & c_latch;
		irq_req_o[igw_pkg::VEC_AR_TIMER] = global_irq_enable &
			((ar_overflow_flag_i & src_ctrl[igw_pkg::CTL_AR_OVF_BIT]) |
			(ar_compare_flag_i & src_ctrl[igw_pkg::CTL_AR_CMP_BIT]) |
			(ar_edge_flag_i & src_ctrl[igw_pkg::CTL_AR_EDGE_BIT]));
		irq_req_o[igw_pkg::VEC_TIMER_ADC] = global_irq_enable &
			((timer_zero_flag_i & src_ctrl[igw_pkg::CTL_TIMER_MASK_BIT]) |
			(adc_eoc_flag_i & src_ctrl[igw_pkg::CTL_ADC_MASK_BIT]));
	end

	// Any request the core would take; NMI counts even with enable low
	assign any_pending = |irq_req_o;
	// Wake only with global enable high, so enable low leaves reset as only exit
	assign wake = global_irq_enable & (|irq_req_o[4:1] | nmi_latch);
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign sleep_req = sleep_wait_i | sleep_stop_i;

	// Edge latches: set wins over the core's acknowledge
	always_comb
	begin
		next_nmi_latch = nmi_latch;
		next_c_latch = c_latch;
		if (irq_ack_i[igw_pkg::VEC_NMI])
		begin
			next_nmi_latch = 1'b0;
		end
		if (nmi_i & ~nmi_prev)
		begin
			next_nmi_latch = 1'b1;
		end
		if (irq_ack_i[igw_pkg::VEC_PORT_C])
		begin
			next_c_latch = 1'b0;
		end
		// Only first edge is kept while one is already stored
		if (c_active & ~c_prev)
		begin
			next_c_latch = 1'b1;
		end
	end

	// Latch registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			nmi_prev <= 1'b0;
			c_prev <= 1'b0;
			nmi_latch <= 1'b0;
			c_latch <= 1'b0;
		end
		else
		begin
			nmi_prev <= nmi_i;
			c_prev <= c_active;
			nmi_latch <= next_nmi_latch;
			c_latch <= next_c_latch;
		end
	end

	// Wishbone slave: one wait state, unmapped reads zero, writes ignored
	always_comb
	begin
		next_interrupt_option_reg = interrupt_option_reg;
		next_src_ctrl = src_ctrl;
		next_port_a = port_a_pin_irq_config;
		next_port_b = port_b_pin_irq_config;
		next_port_c = port_c_pin_irq_config;
		next_dat = 32'h00000000;
		next_ack = bus_req;
		if (bus_req & wb_we_i)
		begin
			case (wb_adr_i)
				igw_pkg::ADDR_INT_OPTION:
				begin
					if (wb_sel_i[0])
					begin
						next_interrupt_option_reg = wb_dat_i[7:0] & igw_pkg::IOR_WRITE_MASK;
					end
				end
				igw_pkg::ADDR_SRC_CTRL:
				begin
					if (wb_sel_i[0])
					begin
						next_src_ctrl = wb_dat_i[7:0];
					end
				end
				igw_pkg::ADDR_PORT_A: next_port_a = lane_merge(port_a_pin_irq_config, wb_dat_i, wb_sel_i);
				igw_pkg::ADDR_PORT_B: next_port_b = lane_merge(port_b_pin_irq_config, wb_dat_i, wb_sel_i);
				igw_pkg::ADDR_PORT_C: next_port_c = lane_merge(port_c_pin_irq_config, wb_dat_i, wb_sel_i);
				default: next_dat = 32'h00000000; // Unmapped or read-only: no effect
			endcase
		end
		else if (bus_req)
		begin
			// Option register is write only and reads as zero
			case (wb_adr_i)
				igw_pkg::ADDR_SRC_CTRL: next_dat = {24'h000000, src_ctrl};
				igw_pkg::ADDR_PORT_A: next_dat = {8'h00, port_a_pin_irq_config};
				igw_pkg::ADDR_PORT_B: next_dat = {8'h00, port_b_pin_irq_config};
				igw_pkg::ADDR_PORT_C: next_dat = {8'h00, port_c_pin_irq_config};
				igw_pkg::ADDR_STATUS:
				begin
					next_dat[igw_pkg::STAT_STATE_LSB +: 2] = state;
					next_dat[igw_pkg::STAT_PEND_LSB +: 5] = irq_req_o;
				end
				default: next_dat = 32'h00000000;
			endcase
		end
	end

	// Register file and bus outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			interrupt_option_reg <= igw_pkg::IOR_RESET;
			src_ctrl <= igw_pkg::CTL_RESET;
			port_a_pin_irq_config <= igw_pkg::PCFG_RESET;
			port_b_pin_irq_config <= igw_pkg::PCFG_RESET;
			port_c_pin_irq_config <= igw_pkg::PCFG_RESET;
			wb_dat_o <= 32'h00000000;
			wb_ack_o <= 1'b0;
		end
		else
		begin
			interrupt_option_reg <= next_interrupt_option_reg;
			src_ctrl <= next_src_ctrl;
			port_a_pin_irq_config <= next_port_a;
			port_b_pin_irq_config <= next_port_b;
			port_c_pin_irq_config <= next_port_c;
			wb_dat_o <= next_dat;
			wb_ack_o <= next_ack;
		end
	end

	// Clock source is only ever changed by software, never by a wake
	assign osc_select_o = src_ctrl[igw_pkg::CTL_OSC_LSB +: 2];
	assign halt_o = (state != igw_pkg::IGW_RUN);
	assign osc_run_o = (state != igw_pkg::IGW_STOP);

	// Sleep sequencer
	always_comb
	begin
		next_state = state;
		next_stab_cnt = stab_cnt;
		next_mode_at_sleep = mode_at_sleep;
		next_resume = 1'b0;
		next_resume_service = resume_service_o;
		next_skip = 1'b0;
		case (state)
			igw_pkg::IGW_RUN:
			begin
				if (sleep_req & any_pending)
				begin
					next_skip = 1'b1;
				end
				else if (sleep_stop_i & ~watchdog_active_i)
				begin
					next_state = igw_pkg::IGW_STOP;
					next_mode_at_sleep = core_mode_i;
				end
				else if (sleep_req)
				begin
					// Stop under a running watchdog becomes wait
					next_state = igw_pkg::IGW_WAIT;
					next_mode_at_sleep = core_mode_i;
				end
			end
			igw_pkg::IGW_WAIT:
			begin
				if (wake)
				begin
					next_state = igw_pkg::IGW_RUN;
					next_resume = 1'b1;
				end
			end
			igw_pkg::IGW_STOP:
			begin
				if (wake)
				begin
					next_state = igw_pkg::IGW_SETTLE;
					next_stab_cnt = igw_pkg::STAB_LOAD;
				end
			end
			igw_pkg::IGW_SETTLE:
			begin
				if (stab_cnt == 11'h000)
				begin
					next_state = igw_pkg::IGW_RUN;
					next_resume = 1'b1;
				end
				else
				begin
					next_stab_cnt = stab_cnt - 11'h001;
				end
			end
			default: next_state = igw_pkg::IGW_RUN;
		endcase
		// Decide whether the core services the waking request first
		if (next_resume)
		begin
			case (mode_at_sleep)
				igw_pkg::MODE_NORMAL: next_resume_service = 1'b1;
				igw_pkg::MODE_IRQ: next_resume_service = nmi_latch;
				default: next_resume_service = 1'b0;
			endcase
		end
	end

	// Sequencer registers; reset from any state is the plain reset path
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= igw_pkg::IGW_RUN;
			stab_cnt <= 11'h000;
			mode_at_sleep <= igw_pkg::MODE_NORMAL;
			resume_o <= 1'b0;
			resume_service_o <= 1'b0;
			skip_o <= 1'b0;
		end
		else
		begin
			state <= next_state;
			stab_cnt <= next_stab_cnt;
			mode_at_sleep <= next_mode_at_sleep;
			resume_o <= next_resume;
			resume_service_o <= next_resume_service;
			skip_o <= next_skip;
		end
	end

	// Checks on the block's own outputs
	a_ior_reset: assert property (@(posedge clk_i) rst_i |=> interrupt_option_reg == 8'h00)
		else $error("option register not cleared by reset");
	a_gen_masks: assert property (@(posedge clk_i) disable iff (rst_i)
		!global_irq_enable |-> irq_req_o[4:1] == 4'h0)
		else $error("maskable request while enable low");
	a_no_wake_gen: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == igw_pkg::IGW_WAIT) && !global_irq_enable |=> state == igw_pkg::IGW_WAIT)
		else $error("woke with enable low");
	a_vec4_route: assert property (@(posedge clk_i) disable iff (rst_i)
		global_irq_enable && timer_zero_flag_i && src_ctrl[igw_pkg::CTL_TIMER_MASK_BIT]
		|-> irq_req_o[igw_pkg::VEC_TIMER_ADC])
		else $error("timer event missing on vector four");
	a_vec3_route: assert property (@(posedge clk_i) disable iff (rst_i)
		global_irq_enable && ar_compare_flag_i && src_ctrl[igw_pkg::CTL_AR_CMP_BIT]
		|-> irq_req_o[igw_pkg::VEC_AR_TIMER])
		else $error("compare event missing on vector three");
	a_wait_nodelay: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == igw_pkg::IGW_WAIT) && wake |=> (state == igw_pkg::IGW_RUN) && resume_o)
		else $error("wait exit not immediate");
	a_stop_settle: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == igw_pkg::IGW_STOP) && wake |=> (state == igw_pkg::IGW_SETTLE) [*8])
		else $error("stop exit skipped settle delay");
	a_stop_osc_off: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == igw_pkg::IGW_STOP) |-> !osc_run_o && halt_o)
		else $error("oscillator running in stop");
	a_stop_as_wait: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == igw_pkg::IGW_RUN) && sleep_stop_i && watchdog_active_i && !any_pending
		|=> state == igw_pkg::IGW_WAIT)
		else $error("stop not turned into wait");
	a_skip_pending: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == igw_pkg::IGW_RUN) && sleep_req && any_pending
		|=> (state == igw_pkg::IGW_RUN) && skip_o)
		else $error("sleep entered with request pending");
	a_nmi_mode_stay: assert property (@(posedge clk_i) disable iff (rst_i)
		resume_o && (mode_at_sleep == igw_pkg::MODE_NMI) |-> !resume_service_o)
		else $error("service requested after sleep in nmi routine");
	a_main_service: assert property (@(posedge clk_i) disable iff (rst_i)
		resume_o && (mode_at_sleep == igw_pkg::MODE_NORMAL) |-> resume_service_o)
		else $error("wake interrupt not serviced from main routine");
	c_wait_wake: cover property (@(posedge clk_i) disable iff (rst_i)
		(state == igw_pkg::IGW_WAIT) ##1 resume_o);
	c_stop_wake: cover property (@(posedge clk_i) disable iff (rst_i)
		(state == igw_pkg::IGW_SETTLE) ##1 (state == igw_pkg::IGW_RUN));
	c_skip: cover property (@(posedge clk_i) disable iff (rst_i) skip_o);
	c_port_c_edge: cover property (@(posedge clk_i) disable iff (rst_i) irq_req_o[2]);
endmodule

/* File: rtl/igw_pkg.sv */
// Purpose: Shared constants for the interrupt gating and low-power wake block
// Assumes: 32-bit classic Wishbone, byte addresses, 8- and 24-bit registers in low bits
// Notes: All offsets, field positions, reset values and timing counts live here
package igw_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_INT_OPTION = 8'hC8; // Interrupt option, write only
	localparam logic [7:0] ADDR_SRC_CTRL = 8'hCC; // Peripheral masks and clock select
	localparam logic [7:0] ADDR_PORT_A = 8'hD0; // Port A direction, option, data
	localparam logic [7:0] ADDR_PORT_B = 8'hD4; // Port B direction, option, data
	localparam logic [7:0] ADDR_PORT_C = 8'hD8; // Port C direction, option, data
	localparam logic [7:0] ADDR_STATUS = 8'hDC; // Sleep state and pending vectors
	// Interrupt option fields
	localparam int IOR_EDGE_POL_BIT = 5; // Edge polarity for source two
	localparam int IOR_GEN_BIT = 4; // Global interrupt enable
	localparam logic [7:0] IOR_WRITE_MASK = 8'h30; // Implemented bits
	localparam logic [7:0] IOR_RESET = 8'h00; // Cleared on reset
	// Source control fields
	localparam int CTL_TIMER_MASK_BIT = 0; // Timer overflow mask
	localparam int CTL_ADC_MASK_BIT = 1; // Converter end-of-conversion mask
	localparam int CTL_AR_OVF_BIT = 2; // Auto-reload overflow enable
	localparam int CTL_AR_CMP_BIT = 3; // Auto-reload compare enable
	localparam int CTL_AR_EDGE_BIT = 4; // Auto-reload input edge enable
	localparam int CTL_OSC_LSB = 6; // Oscillator source select, two bits
	localparam logic [7:0] CTL_RESET = 8'h00; // Control reset value
	// Port config layout: direction [7:0], option [15:8], data [23:16]
	localparam int PCFG_OPT_LSB = 8; // Option byte position
	localparam int PCFG_DATA_LSB = 16; // Data byte position
	localparam logic [23:0] PCFG_RESET = 24'h000000; // Input, pull-up, no interrupt
	// Status fields
	localparam int STAT_STATE_LSB = 0; // Sleep state, two bits
	localparam int STAT_PEND_LSB = 8; // Pending vectors, five bits
	// Vector numbers
	localparam int VEC_NMI = 0; // Non-maskable source
	localparam int VEC_PORT_AB = 1; // Ports A and B pins
	localparam int VEC_PORT_C = 2; // Port C pins, edge
	localparam int VEC_AR_TIMER = 3; // Auto-reload timer events
	localparam int VEC_TIMER_ADC = 4; // Timer and converter
	// Core execution modes
	localparam logic [1:0] MODE_NORMAL = 2'h0; // Main routine
	localparam logic [1:0] MODE_IRQ = 2'h1; // Maskable interrupt routine
	localparam logic [1:0] MODE_NMI = 2'h2; // Non-maskable routine
	// Timing
	localparam int CLK_PERIOD_NS = 100; // 10 MHz core clock
	localparam int STAB_TIME_NS = 100000; // Oscillator settle time after stop
	localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [10:0] STAB_LOAD = 11'(STAB_CYCLES - 1); // Counter start value
	// Sleep sequencer, Gray along run-wait-run and run-stop-settle
	typedef enum logic [1:0] {
		IGW_RUN = 2'h0,
		IGW_STOP = 2'h1,
		IGW_SETTLE = 2'h3,
		IGW_WAIT = 2'h2
	} igw_state_type;
endpackage

/* File: tb/test_igw_ctrl.sv */
// Purpose: Self-checking bench for the interrupt gating and low-power wake block
// Assumes: Bench drives every port itself; Wishbone classic single cycles
// Notes: Stop settle length follows the package constant, about 1000 cycles
`timescale 1ns/1ns
module test_igw_ctrl;
	logic clk_i = 1'b0; // Core clock
	logic rst_i = 1'b1; // Synchronous reset
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0; // Bus request
	logic [7:0] wb_adr_i = 8'h00; // Bus address
	logic [31:0] wb_dat_i = 32'h0; // Bus write data
	logic [31:0] wb_dat_o; // Bus read data
	logic wb_ack_o; // Bus acknowledge
	logic nmi_i = 1'b0; // Non-maskable line
	logic [4:0] flg = 5'h00; // Timer, adc, ar ovf, ar cmp, ar edge flags
	logic [7:0] port_a_i = 8'hFF, port_b_i = 8'hFF, port_c_i = 8'h00; // Pins
	logic [4:0] irq_ack_i = 5'h00; // Routine entry strobes
	logic [1:0] core_mode_i = 2'h0; // Execution mode
	logic sleep_wait_i = 1'b0, sleep_stop_i = 1'b0, watchdog_active_i = 1'b0; // Sleep
	logic [4:0] irq_req_o; // Requests
	logic halt_o, osc_run_o, resume_o, resume_service_o, skip_o; // Sequencer
	logic [1:0] osc_select_o; // Oscillator pick
	int n_mismatch = 0; // Mismatch count
	int num_checks = 0; // Comparison count
	int n; // Wake latency
	logic [31:0] rd; // Read back
	logic [1:0] mode_tab [4] = '{igw_pkg::MODE_NORMAL, igw_pkg::MODE_NMI,
		igw_pkg::MODE_IRQ, igw_pkg::MODE_IRQ}; // Mode before sleep
	logic [3:0] nmi_sel = 4'h8; // Which wake uses the NMI line
	logic [3:0] svc_exp = 4'h9; // Expected service-first flag
	logic [4:0] route_exp [5] = '{5'h10, 5'h00, 5'h08, 5'h08, 5'h08}; // Per flag

	igw_ctrl i_igw_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nmi_i(nmi_i),
		.timer_zero_flag_i(flg[0]), .adc_eoc_flag_i(flg[1]), .ar_overflow_flag_i(flg[2]),
		.ar_compare_flag_i(flg[3]), .ar_edge_flag_i(flg[4]), .port_a_i(port_a_i),
		.port_b_i(port_b_i), .port_c_i(port_c_i), .irq_ack_i(irq_ack_i),
		.core_mode_i(core_mode_i), .sleep_wait_i(sleep_wait_i), .sleep_stop_i(sleep_stop_i),
		.watchdog_active_i(watchdog_active_i), .irq_req_o(irq_req_o), .halt_o(halt_o),
		.osc_run_o(osc_run_o), .osc_select_o(osc_select_o), .resume_o(resume_o),
		.resume_service_o(resume_service_o), .skip_o(skip_o));

	// Free-running core clock, 100 ns period
	always #50 clk_i = ~clk_i;

	// Compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One classic cycle; request held until ack is sampled, the watchdog ends a hang
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// Pulse a sleep instruction, return once it has been taken
	task automatic sleep(input logic stop);
		@(posedge clk_i);
		sleep_stop_i <= stop;
		sleep_wait_i <= ~stop;
		@(posedge clk_i);
		sleep_stop_i <= 1'b0;
		sleep_wait_i <= 1'b0;
		#1;
	endtask

	// Bounded wait for the resume pulse; n holds the cycles spent
	task automatic wait_resume();
		n = 0;
		do
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		while (resume_o !== 1'b1 && n < 3000);
		check("resume seen", resume_o, 1'b1);
	endtask

	// Hold reset for five clocks
	task automatic do_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
	endtask

	// Single exit point of the run
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Hang guard, well beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		summarize();
	end

	initial
	begin
		do_reset();
		check("req after reset", irq_req_o, 5'h00);
		check("halt after reset", {halt_o, osc_run_o}, 2'h1);
		wb(1'b1, igw_pkg::ADDR_INT_OPTION, 32'h30);
		wb(1'b0, igw_pkg::ADDR_INT_OPTION, 32'h0);
		check("option reads zero", rd, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		check("unmapped read", rd, 32'h0);
		do_reset();
		flg <= 5'h01; // Timer event that a stale enable would pass
		wb(1'b1, igw_pkg::ADDR_SRC_CTRL, 32'h9D); // Osc pick 2, adc mask left off
		check("enable cleared by reset", irq_req_o, 5'h00);
		$display("test reset done");
		// Event routing with the global enable set
		wb(1'b1, igw_pkg::ADDR_INT_OPTION, 32'h10);
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk_i);
			flg <= 5'h01 << i;
			@(posedge clk_i);
			#1;
			check("routing", irq_req_o, route_exp[i]);
		end
		flg <= 5'h02; // Converter event only
		wb(1'b1, igw_pkg::ADDR_SRC_CTRL, 32'h9F);
		check("adc routing", irq_req_o, 5'h10);
		flg <= 5'h1F;
		wb(1'b1, igw_pkg::ADDR_INT_OPTION, 32'h00);
		check("global disable", irq_req_o, 5'h00);
		wb(1'b1, igw_pkg::ADDR_INT_OPTION, 32'h10);
		flg <= 5'h00;
		// Port pins: only pull-up input with interrupt counts
		port_b_i <= 8'h00;
		wb(1'b1, igw_pkg::ADDR_PORT_A, 32'h000100);
		check("unconfigured pins", irq_req_o, 5'h00);
		port_a_i <= 8'hFE;
		@(posedge clk_i);
		#1;
		check("port a vector", irq_req_o, 5'h02);
		port_a_i <= 8'hFF;
		// Rising mode first, so enabling the pin itself makes no edge
		wb(1'b1, igw_pkg::ADDR_INT_OPTION, 32'h30);
		wb(1'b1, igw_pkg::ADDR_PORT_C, 32'h000100);
		check("port c idle", irq_req_o, 5'h00);
		port_c_i <= 8'h01;
		repeat (2) @(posedge clk_i);
		#1;
		check("port c rising", irq_req_o, 5'h04);
		sleep(1'b0);
		check("skip pulse", {skip_o, halt_o}, 2'h2);
		irq_ack_i <= 5'h04;
		@(posedge clk_i);
		irq_ack_i <= 5'h00;
		wb(1'b1, igw_pkg::ADDR_INT_OPTION, 32'h10);
		check("port c cleared", irq_req_o, 5'h00);
		port_c_i <= 8'h00;
		repeat (2) @(posedge clk_i);
		#1;
		check("port c falling", irq_req_o, 5'h04);
		irq_ack_i <= 5'h04;
		@(posedge clk_i);
		irq_ack_i <= 5'h00;
		$display("test routing done");
		// Wait exits from each core mode, by maskable event or NMI
		for (int i = 0; i < 4; i++)
		begin
			core_mode_i <= mode_tab[i];
			sleep(1'b0);
			check("wait entry", {halt_o, osc_run_o}, 2'h3);
			@(posedge clk_i);
			if (nmi_sel[i])
				nmi_i <= 1'b1;
			else
				flg <= 5'h01;
			wait_resume();
			check("no wait delay", n <= 2, 1'b1);
			check("service first", resume_service_o, svc_exp[i]);
			@(posedge clk_i);
			flg <= 5'h00;
			nmi_i <= 1'b0;
			irq_ack_i <= 5'h01;
			@(posedge clk_i);
			irq_ack_i <= 5'h00;
		end
		core_mode_i <= 2'h0;
		$display("test wait done");
		// Stop with oscillator settle, then stop turned into wait
		sleep(1'b1);
		check("stop entry", {halt_o, osc_run_o}, 2'h2);
		flg <= 5'h01;
		wait_resume();
		check("settle length", n >= igw_pkg::STAB_CYCLES, 1'b1);
		check("osc pick kept", osc_select_o, 2'h2);
		flg <= 5'h00;
		watchdog_active_i <= 1'b1;
		sleep(1'b1);
		check("stop as wait", {halt_o, osc_run_o}, 2'h3);
		flg <= 5'h01;
		wait_resume();
		check("watchdog wake", n <= 2, 1'b1);
		flg <= 5'h00;
		watchdog_active_i <= 1'b0;
		$display("test stop done");
		// Enable low: NMI requests but cannot wake, reset does
		wb(1'b1, igw_pkg::ADDR_INT_OPTION, 32'h00);
		sleep(1'b0);
		nmi_i <= 1'b1;
		flg <= 5'h01;
		repeat (6) @(posedge clk_i);
		#1;
		check("nmi still requests", irq_req_o, 5'h01);
		check("no wake", {halt_o, resume_o}, 2'h2);
		do_reset();
		check("reset wakes", {halt_o, resume_o}, 2'h0);
		wb(1'b0, igw_pkg::ADDR_STATUS, 32'h0);
		check("status after reset", rd[1:0], igw_pkg::IGW_RUN);
		$display("test enable low done");
		summarize();
	end
endmodule
